// File: rtl/scsi_stat_defines.svh
/*
 Register offsets, field positions and reset values of the SCSI status
 and interrupt reporting block.
 Assumes byte offsets on the host register port, one register a word.
*/
`ifndef SCSI_STAT_DEFINES_SVH
`define SCSI_STAT_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_COMMAND 8'h0C
`define OFS_CTRL_STATUS 8'h10
`define OFS_INT_CAUSE 8'h14
`define OFS_INT_MASK 8'h40

// ****************************************************************
// Controller status fields
// ****************************************************************
`define ST_PEND_BIT 7
`define ST_GROSS_BIT 6
`define ST_PARITY_BIT 5
`define ST_TC_BIT 4
`define ST_VGC_BIT 3
`define ST_PHASE_MSB 2
`define ST_PHASE_LSB 0

// ****************************************************************
// Interrupt cause fields
// ****************************************************************
`define IC_BUS_RESET_BIT 7
`define IC_ILLEGAL_BIT 6
`define IC_DISCONNECT_BIT 5
`define IC_SERVICE_BIT 4
`define IC_FUNC_DONE_BIT 3
`define IC_RESELECT_BIT 2
`define IC_SEL_ATN_BIT 1
`define IC_SELECTED_BIT 0

// ****************************************************************
// Command fields and reset values
// ****************************************************************
`define CMD_DMA_BIT 7
`define CMD_DEPTH 2
`define RST_INT_MASK 8'hFF
`define RST_BYTE 8'h00

`endif

// File: rtl/scsi_stat_pkg.sv
/*
 Types shared by the SCSI status and interrupt reporting block.
 Assumes the constants header is compiled alongside.
*/
package scsi_stat_pkg;
   typedef logic [7:0] byte_t;

   typedef enum logic [2:0] {
      PH_DATA_OUT = 3'b000,
      PH_DATA_IN = 3'b001,
      PH_COMMAND = 3'b010,
      PH_STATUS = 3'b011,
      PH_RSVD4 = 3'b100,
      PH_RSVD5 = 3'b101,
      PH_MSG_OUT = 3'b110,
      PH_MSG_IN = 3'b111
   } scsi_phase_t;
endpackage : scsi_stat_pkg

// File: rtl/irq_bank_if.sv
/*
 Carrier between the register front end and the interrupt cause bank.
 Assumes both ends run on core_clk.
*/
`timescale 1ns/10ps
interface irq_bank_if;
   import scsi_stat_pkg::*;
   byte_t set_evt;
   logic read_clr;
   logic mask_wr;
   byte_t mask_wdata;
   byte_t cause;
   byte_t mask;
   logic pending;
   logic irq;

   modport front (
      output set_evt, read_clr, mask_wr, mask_wdata,
      input cause, mask, pending, irq
   );
   modport bank (
      input set_evt, read_clr, mask_wr, mask_wdata,
      output cause, mask, pending, irq
   );
endinterface : irq_bank_if

// File: rtl/irq_cause_bank.sv
/*
 Sticky interrupt cause bits, cleared by a read, with a mask and one
 level interrupt output.
 Assumes read_clr is a one-cycle pulse from the register front end.
*/
`timescale 1ns/10ps
`include "scsi_stat_defines.svh"
module irq_cause_bank (
   input wire logic core_clk,
   input wire logic rst_n,
   irq_bank_if.bank bnk
);
   import scsi_stat_pkg::*;

   byte_t cause_q;
   byte_t cause_d;
   byte_t mask_q;
   byte_t mask_d;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      // An event in the clearing cycle survives the clear
      cause_d = bnk.read_clr ? bnk.set_evt : (cause_q | bnk.set_evt);
      mask_d = bnk.mask_wr ? bnk.mask_wdata : mask_q;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cause_q <= `RST_BYTE;
         mask_q <= `RST_INT_MASK;
      end else begin
         cause_q <= cause_d;
         mask_q <= mask_d;
      end
   end

   assign bnk.cause = cause_q;
   assign bnk.mask = mask_q;
   assign bnk.pending = |cause_q;
   assign bnk.irq = |(cause_q & mask_q);
endmodule : irq_cause_bank

// File: rtl/scsi_status_irq_reporting.sv
/*
 Status and interrupt-cause reporting of a SCSI bus controller:
 controller status, read-to-clear interrupt cause, interrupt mask,
 a two-deep command register with illegal-command detection.
 Assumes event inputs are one-cycle pulses on core_clk and the bus
 phase lines come from pins.
*/
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "scsi_stat_defines.svh"
module scsi_status_irq_reporting (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire scsi_stat_pkg::byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output scsi_stat_pkg::byte_t reg_rdata,
   input wire logic fifo_top_overwrite,
   input wire logic dma_dir_conflict,
   input wire logic init_sync_phase_change,
   input wire logic parity_err_evt,
   input wire logic term_count_evt,
   input wire logic group_code_valid,
   input wire logic [2:0] bus_phase_pins,
   input wire logic bus_reset_evt,
   input wire logic disconnect_evt,
   input wire logic bus_service_evt,
   input wire logic func_complete_evt,
   input wire logic reselected_evt,
   input wire logic selected_atn_evt,
   input wire logic selected_evt,
   output scsi_stat_pkg::byte_t cmd_head,
   output logic cmd_avail,
   input wire logic cmd_taken,
   output logic irq
);
   import scsi_stat_pkg::*;

   // ****************************************************************
   // Command legality
   // ****************************************************************
   // Bit 7 is the DMA enable and plays no part in legality
   function automatic logic cmd_is_legal(input logic [6:0] code);
      logic ok;
      ok = 1'b0;
      case (code)
         // Immediate group
         7'h00: ok = 1'b1;
         7'h01: ok = 1'b1;
         7'h02: ok = 1'b1;
         7'h03: ok = 1'b1;
         // Initiator group
         7'h10: ok = 1'b1;
         7'h11: ok = 1'b1;
         7'h12: ok = 1'b1;
         7'h18: ok = 1'b1;
         7'h1A: ok = 1'b1;
         7'h1B: ok = 1'b1;
         // Target group
         7'h20: ok = 1'b1;
         7'h21: ok = 1'b1;
         7'h22: ok = 1'b1;
         7'h23: ok = 1'b1;
         7'h24: ok = 1'b1;
         7'h25: ok = 1'b1;
         7'h27: ok = 1'b1;
         7'h28: ok = 1'b1;
         7'h29: ok = 1'b1;
         7'h2A: ok = 1'b1;
         7'h2B: ok = 1'b1;
         7'h2C: ok = 1'b1;
         // Disconnected group
         7'h40: ok = 1'b1;
         7'h41: ok = 1'b1;
         7'h42: ok = 1'b1;
         7'h43: ok = 1'b1;
         7'h44: ok = 1'b1;
         7'h45: ok = 1'b1;
         7'h46: ok = 1'b1;
         7'h47: ok = 1'b1;
         default: begin
            ok = 1'b0;
         end
      endcase
      return ok;
   endfunction : cmd_is_legal

   function automatic logic addr_hit(input logic [7:0] a,
      input logic [7:0] ofs);
      return a == ofs;
   endfunction : addr_hit

   // ****************************************************************
   // Declarations
   // ****************************************************************
   irq_bank_if bank_if ();

   logic [2:0] phase_m_q;
   logic [2:0] phase_s_q;
   logic [2:0] phase_s_d;
   logic gross_q;
   logic gross_d;
   logic parity_q;
   logic parity_d;
   logic tc_q;
   logic tc_d;
   logic vgc_q;
   logic vgc_d;
   byte_t cmd_mem_q [`CMD_DEPTH];
   byte_t cmd_mem_d [`CMD_DEPTH];
   logic [1:0] cmd_cnt_q;
   logic [1:0] cmd_cnt_d;
   byte_t rdata_q;
   byte_t rdata_d;
   byte_t status_word;
   logic cmd_wr;
   logic cmd_full;
   logic cmd_overwrite;
   logic cmd_illegal;
   logic cause_rd;

   // ****************************************************************
   // Register port decode
   // ****************************************************************
   // Unmapped offsets read as zero; writes to read-only ones are dropped
   // A pop in the same cycle makes room, so no overwrite is flagged
   always_comb begin
      cmd_wr = reg_wr && addr_hit(reg_addr, `OFS_COMMAND);
      cause_rd = reg_rd && addr_hit(reg_addr, `OFS_INT_CAUSE);
      cmd_full = (cmd_cnt_q == 2'(`CMD_DEPTH)) && !cmd_taken;
      cmd_overwrite = cmd_wr && cmd_full;
      cmd_illegal = cmd_wr && !cmd_is_legal(reg_wdata[6:0]);
   end

   // ****************************************************************
   // Bus phase synchroniser
   // ****************************************************************
   // Phase pins are asynchronous: only the second stage is read
   // Reserved codes pass through unchanged
   always_comb begin
      phase_s_d = phase_m_q;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         phase_m_q <= 3'h0;
         phase_s_q <= 3'h0;
      end else begin
         phase_m_q <= bus_phase_pins;
         phase_s_q <= phase_s_d;
      end
   end

   // ****************************************************************
   // Error and count flags
   // ****************************************************************
   // Gross, parity and count flags clear with the cause read; a new event in that cycle wins
   always_comb begin
      gross_d = (gross_q && !cause_rd)
         || fifo_top_overwrite || cmd_overwrite
         || dma_dir_conflict || init_sync_phase_change;
      parity_d = (parity_q && !cause_rd) || parity_err_evt;
      tc_d = (tc_q && !cause_rd) || term_count_evt;
      // Group code flag mirrors its input, one cycle late
      vgc_d = group_code_valid;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         gross_q <= 1'b0;
         parity_q <= 1'b0;
         tc_q <= 1'b0;
         vgc_q <= 1'b0;
      end else begin
         gross_q <= gross_d;
         parity_q <= parity_d;
         tc_q <= tc_d;
         vgc_q <= vgc_d;
      end
   end

   // ****************************************************************
   // Two-deep command register
   // ****************************************************************
   // A write to a full pair replaces the newest entry and flags an error
   always_comb begin
      cmd_mem_d = cmd_mem_q;
      cmd_cnt_d = cmd_cnt_q;
      if (cmd_taken && cmd_cnt_q != 2'h0) begin
         cmd_mem_d[0] = cmd_mem_q[1];
         cmd_cnt_d = cmd_cnt_q - 2'h1;
      end
      if (cmd_wr) begin
         if (cmd_cnt_d == 2'(`CMD_DEPTH)) begin
            cmd_mem_d[`CMD_DEPTH - 1] = reg_wdata;
         end else begin
            cmd_mem_d[cmd_cnt_d[0]] = reg_wdata;
            cmd_cnt_d = cmd_cnt_d + 2'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cmd_mem_q[0] <= `RST_BYTE;
         cmd_mem_q[1] <= `RST_BYTE;
         cmd_cnt_q <= 2'h0;
      end else begin
         cmd_mem_q <= cmd_mem_d;
         cmd_cnt_q <= cmd_cnt_d;
      end
   end

   // Oldest entry is always kept in slot 0
   assign cmd_head = cmd_mem_q[0];
   assign cmd_avail = (cmd_cnt_q != 2'h0);

   // ****************************************************************
   // Interrupt cause bank
   // ****************************************************************
   always_comb begin
      bank_if.set_evt = `RST_BYTE;
      bank_if.set_evt[`IC_BUS_RESET_BIT] = bus_reset_evt;
      bank_if.set_evt[`IC_ILLEGAL_BIT] = cmd_illegal;
      bank_if.set_evt[`IC_DISCONNECT_BIT] = disconnect_evt;
      bank_if.set_evt[`IC_SERVICE_BIT] = bus_service_evt;
      bank_if.set_evt[`IC_FUNC_DONE_BIT] = func_complete_evt;
      bank_if.set_evt[`IC_RESELECT_BIT] = reselected_evt;
      bank_if.set_evt[`IC_SEL_ATN_BIT] = selected_atn_evt;
      bank_if.set_evt[`IC_SELECTED_BIT] = selected_evt;
      bank_if.read_clr = cause_rd;
      bank_if.mask_wr = reg_wr && addr_hit(reg_addr, `OFS_INT_MASK);
      bank_if.mask_wdata = reg_wdata;
   end

   irq_cause_bank u_bank (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .bnk(bank_if.bank)
   );

   assign irq = bank_if.irq;

   // ****************************************************************
   // Read data
   // ****************************************************************
   always_comb begin
      status_word = `RST_BYTE;
      status_word[`ST_PEND_BIT] = bank_if.pending;
      status_word[`ST_GROSS_BIT] = gross_q;
      status_word[`ST_PARITY_BIT] = parity_q;
      status_word[`ST_TC_BIT] = tc_q;
      status_word[`ST_VGC_BIT] = vgc_q;
      status_word[`ST_PHASE_MSB:`ST_PHASE_LSB] = phase_s_q;
   end

   // Cause value is captured before the read clears it
   // Read data stand for one cycle only and are zero otherwise
   always_comb begin
      rdata_d = `RST_BYTE;
      if (reg_rd) begin
         case (reg_addr)
            `OFS_CTRL_STATUS: begin
               rdata_d = status_word;
            end
            `OFS_INT_CAUSE: begin
               rdata_d = bank_if.cause;
            end
            `OFS_INT_MASK: begin
               rdata_d = bank_if.mask;
            end
            `OFS_COMMAND: begin
               rdata_d = cmd_mem_q[0];
            end
            default: begin
               rdata_d = `RST_BYTE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_q <= `RST_BYTE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
endmodule : scsi_status_irq_reporting

// File: dv/scsi_stat_assertions.sv
/*
 Concurrent checks of the SCSI status and interrupt reporting block.
 Assumes it is bound to the top module and that the whole block runs
 on core_clk.
*/
`timescale 1ns/10ps
`include "scsi_stat_defines.svh"
module scsi_stat_assertions (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire scsi_stat_pkg::byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire scsi_stat_pkg::byte_t reg_rdata,
   input wire logic fifo_top_overwrite,
   input wire logic dma_dir_conflict,
   input wire logic init_sync_phase_change,
   input wire logic [2:0] bus_phase_pins,
   input wire logic bus_reset_evt,
   input wire logic disconnect_evt,
   input wire logic bus_service_evt,
   input wire logic func_complete_evt,
   input wire logic reselected_evt,
   input wire logic selected_atn_evt,
   input wire logic selected_evt,
   input wire logic cmd_avail,
   input wire logic irq
);
   import scsi_stat_pkg::*;
   logic [2:0] age_q;
   logic [2:0] age_d;
   logic [2:0] pins_q;
   logic rd_st;
   logic rd_ic;
   logic evts;

   assign rd_st = reg_rd && reg_addr == `OFS_CTRL_STATUS;
   assign rd_ic = reg_rd && reg_addr == `OFS_INT_CAUSE;
   assign evts = bus_reset_evt | disconnect_evt | bus_service_evt |
      func_complete_evt | reselected_evt | selected_atn_evt | selected_evt;

   // ****************************************************************
   // Age of the phase pins, so reads past the synchroniser are known
   // ****************************************************************
   always_comb begin
      age_d = 3'h0;
      if (bus_phase_pins == pins_q) begin
         age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         age_q <= 3'h0;
         pins_q <= 3'h0;
      end else begin
         age_q <= age_d;
         pins_q <= bus_phase_pins;
      end
   end

   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_pend_bit:
   assert property (irq && rd_st |=> reg_rdata[7])
      else $error("pending bit low while irq high");
   chk_cause_clear:
   assert property (rd_ic && !evts |=> !irq)
      else $error("irq stays high after cause read");
   chk_reset_irq:
   assert property (bus_reset_evt |=> irq)
      else $error("bus reset event raised no irq");
   chk_gross_fifo:
   assert property (fifo_top_overwrite ##1 !reg_rd ##1 rd_st
      |=> reg_rdata[6]) else $error("gross error missing after overwrite");
   chk_gross_dir:
   assert property ((dma_dir_conflict || init_sync_phase_change)
      ##1 !reg_rd ##1 rd_st |=> reg_rdata[6])
      else $error("gross error missing after clash");
   chk_illegal_cmd:
   assert property (reg_wr && reg_addr == `OFS_COMMAND &&
      reg_wdata[6:4] == 3'b111 ##1 !reg_rd ##1 rd_ic |=> reg_rdata[6])
      else $error("illegal command not flagged");
   chk_phase_field:
   assert property (rd_st && age_q >= 3'h4 |=> reg_rdata[2:0] == pins_q)
      else $error("phase field differs from pins");
   chk_cmd_store:
   assert property (reg_wr && reg_addr == `OFS_COMMAND |=> cmd_avail)
      else $error("written command not stored");
endmodule : scsi_stat_assertions

// File: dv/scsi_status_irq_reporting_tb_top.sv
/*
 Self-checking bench of the SCSI status and interrupt reporting block.
 Assumes the design files and the checker are compiled before it.
*/
`timescale 1ns/10ps
`include "scsi_stat_defines.svh"
module scsi_status_irq_reporting_tb_top;
   import scsi_stat_pkg::*;
   logic core_clk, rst_n, reg_wr, reg_rd, cmd_taken, gcv, cmd_avail, irq;
   logic [7:0] reg_addr;
   byte_t reg_wdata, reg_rdata, cmd_head;
   logic [12:0] ev_q;
   logic [2:0] pins;
   int err_count, checks_done;
   byte_t codes [5] = '{8'h70, 8'h50, 8'h60, 8'h04, 8'h26};

   scsi_status_irq_reporting scsi_status_irq_reporting_i (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .fifo_top_overwrite(ev_q[8]),
      .dma_dir_conflict(ev_q[9]), .init_sync_phase_change(ev_q[10]),
      .parity_err_evt(ev_q[11]), .term_count_evt(ev_q[12]),
      .group_code_valid(gcv), .bus_phase_pins(pins),
      .bus_reset_evt(ev_q[7]), .disconnect_evt(ev_q[5]),
      .bus_service_evt(ev_q[4]), .func_complete_evt(ev_q[3]),
      .reselected_evt(ev_q[2]), .selected_atn_evt(ev_q[1]),
      .selected_evt(ev_q[0]), .cmd_head(cmd_head), .cmd_avail(cmd_avail),
      .cmd_taken(cmd_taken), .irq(irq));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // ****************************************************************
   // Access tasks
   // ****************************************************************
   task automatic chk(input byte_t got, input byte_t exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input byte_t d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input byte_t m, input byte_t e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata & m, e);
   endtask : rd
   task automatic pulse(input int k);
      @(posedge core_clk);
      ev_q[k] <= 1'b1;
      @(posedge core_clk);
      ev_q <= '0;
      #1;
   endtask : pulse
   task automatic pop();
      @(posedge core_clk);
      cmd_taken <= 1'b1;
      @(posedge core_clk);
      cmd_taken <= 1'b0;
      #1;
   endtask : pop
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize

   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      $display("[ERR] %0t run limit reached", $time);
      summarize();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      {rst_n, reg_wr, reg_rd, cmd_taken, gcv, reg_addr, reg_wdata} = '0;
      ev_q = '0;
      pins = 3'h0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(`OFS_CTRL_STATUS, 8'hFF, 8'h00);
      rd(`OFS_INT_CAUSE, 8'hFF, 8'h00);
      rd(`OFS_INT_MASK, 8'hFF, 8'hFF);
      rd(8'h20, 8'hFF, 8'h00);
      chk({7'h0, irq}, 8'h00);
      $display("test reset done");
      for (int b = 0; b < 8; b++) begin
         if (b != 6) begin
            pulse(b);
            chk({7'h0, irq}, 8'h01);
            rd(`OFS_CTRL_STATUS, 8'h80, 8'h80);
            rd(`OFS_INT_CAUSE, 8'hFF, 8'h01 << b);
            chk({7'h0, irq}, 8'h00);
            rd(`OFS_CTRL_STATUS, 8'h80, 8'h00);
            rd(`OFS_INT_CAUSE, 8'hFF, 8'h00);
         end
      end
      $display("test causes done");
      for (int k = 8; k < 13; k++) begin
         pulse(k);
         rd(`OFS_CTRL_STATUS, 8'hF8, k == 11 ? 8'h20 :
            k == 12 ? 8'h10 : 8'h40);
         rd(`OFS_INT_CAUSE, 8'hFF, 8'h00);
         rd(`OFS_CTRL_STATUS, 8'hF8, 8'h00);
      end
      $display("test flags done");
      foreach (codes[i]) begin
         wr(`OFS_COMMAND, codes[i]);
         chk(cmd_head, codes[i]);
         rd(`OFS_INT_CAUSE, 8'hFF, 8'h40);
         pop();
      end
      wr(`OFS_COMMAND, 8'h12);
      rd(`OFS_COMMAND, 8'hFF, 8'h12);
      rd(`OFS_INT_CAUSE, 8'hFF, 8'h00);
      wr(`OFS_COMMAND, 8'h10);
      wr(`OFS_COMMAND, 8'h11);
      rd(`OFS_CTRL_STATUS, 8'h40, 8'h40);
      chk(cmd_head, 8'h12);
      pop();
      chk(cmd_head, 8'h11);
      pop();
      chk({7'h0, cmd_avail}, 8'h00);
      rd(`OFS_INT_CAUSE, 8'hFF, 8'h00);
      $display("test commands done");
      for (int p = 0; p < 8; p++) begin
         @(posedge core_clk);
         pins <= p[2:0];
         repeat (4) @(posedge core_clk);
         rd(`OFS_CTRL_STATUS, 8'h07, {5'h0, p[2:0]});
      end
      pins <= 3'h0;
      $display("test phase done");
      wr(`OFS_INT_MASK, 8'hFE);
      pulse(0);
      chk({7'h0, irq}, 8'h00);
      rd(`OFS_CTRL_STATUS, 8'h80, 8'h80);
      rd(`OFS_INT_CAUSE, 8'hFF, 8'h01);
      wr(`OFS_INT_MASK, 8'hFF);
      wr(`OFS_CTRL_STATUS, 8'hFF);
      wr(8'h20, 8'hFF);
      rd(`OFS_CTRL_STATUS, 8'hF8, 8'h00);
      @(posedge core_clk);
      gcv <= 1'b1;
      rd(`OFS_CTRL_STATUS, 8'h08, 8'h08);
      gcv <= 1'b0;
      $display("test mask done");
      summarize();
   end
endmodule : scsi_status_irq_reporting_tb_top

bind scsi_status_irq_reporting scsi_stat_assertions scsi_stat_assertions_i (
   .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .fifo_top_overwrite, .dma_dir_conflict, .init_sync_phase_change,
   .bus_phase_pins, .bus_reset_evt, .disconnect_evt, .bus_service_evt,
   .func_complete_evt, .reselected_evt, .selected_atn_evt, .selected_evt,
   .cmd_avail, .irq);
